// *** as_cfg_pkg.sv ***
// Constants, register map and state type of the serial configuration loader
package as_cfg_pkg;
  // Clock rates and derived cycle counts
  localparam int SYS_KHZ         = 100000;
  localparam int LCLK_TYP_KHZ    = 17000;
  localparam int LCLK_HALF       = (SYS_KHZ + LCLK_TYP_KHZ) / (2 * LCLK_TYP_KHZ);
  localparam int INIT_OSC_KHZ    = 10000;
  localparam int INIT_DIV        = SYS_KHZ / INIT_OSC_KHZ;
  localparam int INIT_CYCLES     = 136;
  localparam int POR_MS          = 100;
  localparam int POR_CYCLES_DEF  = POR_MS * SYS_KHZ;
  localparam int RESTART_US      = 30;
  localparam int RESTART_CYCLES  = RESTART_US * SYS_KHZ / 1000;
  localparam int CS_PULSE_NS     = 100;
  localparam int CS_PULSE_CYCLES = (CS_PULSE_NS * SYS_KHZ + 999999) / 1000000;
  // Memory read command, start address and scheme code
  localparam logic [7:0]  READ_CMD  = 8'h03;
  localparam logic [23:0] READ_ADDR = 24'h000000;
  localparam int          CMD_BITS  = 32;
  localparam logic [1:0]  AS_SCHEME = 2'h0;
  // Register offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LEN_OFF  = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  // Field positions and reset values
  localparam int          CTRL_AUTO_BIT = 0;
  localparam int          CTRL_UCLK_BIT = 1;
  localparam int          CTRL_COMP_BIT = 2;
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam logic [23:0] LEN_RST       = 24'h000010;
  localparam int          STAT_ERR_BIT  = 4;
  localparam int          STAT_IDE_BIT  = 5;
  localparam int          STAT_USER_BIT = 6;
  // Compressed stream: upper nibble marks a zero run
  localparam logic [3:0]  RUN_CODE = 4'hf;
  // Loader states
  typedef enum logic [3:0] {
    ST_POR      = 4'h0,
    ST_WAIT_ST  = 4'h1,
    ST_CMD      = 4'h2,
    ST_DATA     = 4'h3,
    ST_WAIT_DN  = 4'h4,
    ST_INIT     = 4'h5,
    ST_USER     = 4'h6,
    ST_ERROR    = 4'h7,
    ST_RESTART  = 4'h8,
    ST_RECONFIG = 4'h9
  } cfg_state_type;
endpackage : as_cfg_pkg

// *** cfg_byte_if.sv ***
// Byte stream carrier between the loader and its decompressor
`timescale 1ns/1ps
interface cfg_byte_if;
  logic       valid;
  logic [7:0] data;
  modport src (output valid, output data);
  modport dst (input valid, input data);
endinterface : cfg_byte_if

// *** pin_sync.sv ***
// Two-stage synchroniser with rising-edge pulses for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync,
  output logic      [W-1:0] o_rise
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // Edge detector reads only the second stage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign o_sync = sync_reg;
  assign o_rise = sync_reg & ~last_reg;
endmodule : pin_sync

// *** stream_decompressor.sv ***
// Zero-run expander for compressed bitstream bytes
`timescale 1ns/1ps
module stream_decompressor (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_enable,
  input  wire logic i_clear,
  cfg_byte_if.dst   in_s,
  cfg_byte_if.src   out_s
);
  logic [3:0] run_reg;
  logic       lit_reg;
  logic       valid_reg;
  logic [7:0] data_reg;

  // Code f0 escapes the next byte; fN gives N zero bytes.
  // Runs are at most 15 bytes, far shorter than one serial byte time.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || i_clear)
    begin
      run_reg   <= 4'h0;
      lit_reg   <= 1'b0;
      valid_reg <= 1'b0;
      data_reg  <= 8'h00;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (run_reg != 4'h0)
      begin
        valid_reg <= 1'b1;
        data_reg  <= 8'h00;
        run_reg   <= run_reg - 4'h1;
      end
      else if (in_s.valid)
      begin
        if (!i_enable || lit_reg || in_s.data[7:4] != as_cfg_pkg::RUN_CODE)
        begin
          valid_reg <= 1'b1;
          data_reg  <= in_s.data;
          lit_reg   <= 1'b0;
        end
        else if (in_s.data[3:0] == 4'h0)
          lit_reg <= 1'b1;
        else
        begin
          valid_reg <= 1'b1;
          data_reg  <= 8'h00;
          run_reg   <= in_s.data[3:0] - 4'h1;
        end
      end
    end
  end

  assign out_s.valid = valid_reg;
  assign out_s.data  = data_reg;
endmodule : stream_decompressor

// *** active_serial_config_master.sv ***
// Active serial configuration loader with APB control registers
//
// Contract
// - Scheme select 00 picks this loading scheme
// - Power-on reset drives status, done low
// - Release status; start when seen high
// - User I/O tri-stated, weak pull-ups on
// - Serial clock from oscillator, 14 to 20 MHz
// - Serial clock stops after loading
// - Launch and capture on falling edge
// - Assert memory select while loading
// - Shift command, address, then receive data
// - Decompress stream when enabled
// - Release done after all bits
// - Initialise only after done seen high
// - Init clock internal or user clock
// - Count 136 init clocks after done
// - Init-done low if enabled, released after
// - User mode: pull-ups off, I/O live
// - Frame error: status low, done low
// - Auto restart: pulse select, wait, retry
// - Request low: lines low, I/O tri-stated
`timescale 1ns/1ps
module active_serial_config_master #(
  parameter int POR_CYCLES = as_cfg_pkg::POR_CYCLES_DEF
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [1:0]  i_scheme_select,
  input  wire logic        i_chain_enable_in_n,
  input  wire logic        i_reconfig_request_n,
  input  wire logic        i_status_line,
  output logic             o_status_line_oe,
  input  wire logic        i_done_line,
  output logic             o_done_line_oe,
  output logic             o_init_done_oe,
  input  wire logic        i_user_startup_clock,
  output logic             o_serial_link_clock,
  output logic             o_command_serial_out,
  output logic             o_memory_chip_select_n,
  input  wire logic        i_bitstream_data_in,
  input  wire logic        i_frame_error,
  output logic             o_cfg_valid,
  output logic      [7:0]  o_cfg_byte,
  output logic             o_user_io_tristate,
  output logic             o_weak_pullup_en
);
  as_cfg_pkg::cfg_state_type state_reg;
  as_cfg_pkg::cfg_state_type state_next;
  logic [7:0]  pin_sync_w;
  logic [7:0]  pin_rise_w;
  logic [2:0]  ctrl_reg;
  logic [23:0] len_reg;
  logic        err_reg;
  logic [31:0] prdata_reg;
  logic [31:0] delay_reg;
  logic [3:0]  lclk_cnt_reg;
  logic        lclk_reg;
  logic [5:0]  bit_cnt_reg;
  logic [31:0] shift_reg;
  logic [7:0]  byte_reg;
  logic [2:0]  byte_bits_reg;
  logic        raw_valid_reg;
  logic [23:0] out_cnt_reg;
  logic        first_reg;
  logic        ide_reg;
  logic [3:0]  init_div_reg;
  logic [7:0]  init_cnt_reg;
  logic        lclk_term;
  logic        lclk_fall;
  logic        init_tick;
  logic        loading;
  logic        wr_en;
  logic        hit;
  logic        frame_err;
  logic        st_ok;
  logic        dn_ok;
  logic        rcfg_n;

  cfg_byte_if raw_if ();
  cfg_byte_if dec_if ();

  // Synchronised pins: status, done, reconfig, data, user clock, chain, scheme
  pin_sync #(
    .W (8)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_async   ({i_scheme_select, i_chain_enable_in_n, i_user_startup_clock,
                 i_bitstream_data_in, i_reconfig_request_n, i_done_line, i_status_line}),
    .o_sync    (pin_sync_w),
    .o_rise    (pin_rise_w)
  );

  assign st_ok  = pin_sync_w[0];
  assign dn_ok  = pin_sync_w[1];
  assign rcfg_n = pin_sync_w[2];

  // Decompressor sits between the serial shifter and the cell writer
  stream_decompressor u_dec (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_enable  (ctrl_reg[as_cfg_pkg::CTRL_COMP_BIT]),
    .i_clear   (state_reg != as_cfg_pkg::ST_DATA),
    .in_s      (raw_if.dst),
    .out_s     (dec_if.src)
  );

  assign raw_if.valid = raw_valid_reg;
  assign raw_if.data  = byte_reg;
  assign o_cfg_valid  = dec_if.valid;
  assign o_cfg_byte   = dec_if.data;

  // APB decode; zero wait states, unmapped offsets answer with an error
  assign wr_en     = i_psel && i_penable && i_pwrite;
  assign hit       = i_paddr == as_cfg_pkg::CTRL_OFF || i_paddr == as_cfg_pkg::LEN_OFF
                     || i_paddr == as_cfg_pkg::STAT_OFF;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata  = prdata_reg;

  // Control and length registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ctrl_reg <= as_cfg_pkg::CTRL_RST;
      len_reg  <= as_cfg_pkg::LEN_RST;
    end
    else if (wr_en && i_paddr == as_cfg_pkg::CTRL_OFF)
      ctrl_reg <= i_pwdata[2:0];
    else if (wr_en && i_paddr == as_cfg_pkg::LEN_OFF)
      len_reg <= i_pwdata[23:0];
  end

  // Sticky frame error; a new error beats the write-one clear
  assign frame_err = state_reg == as_cfg_pkg::ST_DATA && i_frame_error;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      err_reg <= 1'b0;
    else if (frame_err)
      err_reg <= 1'b1;
    else if (wr_en && i_paddr == as_cfg_pkg::STAT_OFF && i_pwdata[as_cfg_pkg::STAT_ERR_BIT])
      err_reg <= 1'b0;
  end

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      prdata_reg <= 32'h0;
    else if (i_psel && !i_penable)
    begin
      if (i_paddr == as_cfg_pkg::CTRL_OFF)
        prdata_reg <= {29'h0, ctrl_reg};
      else if (i_paddr == as_cfg_pkg::LEN_OFF)
        prdata_reg <= {8'h0, len_reg};
      else if (i_paddr == as_cfg_pkg::STAT_OFF)
        prdata_reg <= {25'h0, state_reg == as_cfg_pkg::ST_USER, ide_reg, err_reg, state_reg};
      else
        prdata_reg <= 32'h0;
    end
  end

  // Sequencer; a low reconfig request overrides all but power-on reset
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      as_cfg_pkg::ST_POR:
        if (delay_reg == 32'(POR_CYCLES - 1))
          state_next = as_cfg_pkg::ST_WAIT_ST;
      as_cfg_pkg::ST_WAIT_ST:
        if (st_ok && pin_sync_w[7:6] == as_cfg_pkg::AS_SCHEME && !pin_sync_w[5])
          state_next = as_cfg_pkg::ST_CMD;
      as_cfg_pkg::ST_CMD:
        if (lclk_fall && bit_cnt_reg == 6'(as_cfg_pkg::CMD_BITS - 1))
          state_next = as_cfg_pkg::ST_DATA;
      as_cfg_pkg::ST_DATA:
        if (i_frame_error)
          state_next = as_cfg_pkg::ST_ERROR;
        else if (dec_if.valid && out_cnt_reg == len_reg - 24'h1)
          state_next = as_cfg_pkg::ST_WAIT_DN;
      as_cfg_pkg::ST_WAIT_DN:
        if (dn_ok)
          state_next = as_cfg_pkg::ST_INIT;
      as_cfg_pkg::ST_INIT:
        if (init_tick && init_cnt_reg == 8'(as_cfg_pkg::INIT_CYCLES - 1))
          state_next = as_cfg_pkg::ST_USER;
      as_cfg_pkg::ST_ERROR:
        if (ctrl_reg[as_cfg_pkg::CTRL_AUTO_BIT])
          state_next = as_cfg_pkg::ST_RESTART;
      as_cfg_pkg::ST_RESTART:
        if (delay_reg == 32'(as_cfg_pkg::RESTART_CYCLES - 1))
          state_next = as_cfg_pkg::ST_WAIT_ST;
      as_cfg_pkg::ST_RECONFIG:
        if (rcfg_n)
          state_next = as_cfg_pkg::ST_WAIT_ST;
      default:
        state_next = state_reg;
    endcase
    if (!rcfg_n && state_reg != as_cfg_pkg::ST_POR)
      state_next = as_cfg_pkg::ST_RECONFIG;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      state_reg <= as_cfg_pkg::ST_POR;
    else
      state_reg <= state_next;
  end

  // Time spent in the current state
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || state_next != state_reg)
      delay_reg <= 32'h0;
    else
      delay_reg <= delay_reg + 32'h1;
  end

  // Serial clock divider, runs only while loading; stopped otherwise
  assign loading   = state_reg == as_cfg_pkg::ST_CMD || state_reg == as_cfg_pkg::ST_DATA;
  assign lclk_term = loading && lclk_cnt_reg == 4'(as_cfg_pkg::LCLK_HALF - 1);
  assign lclk_fall = lclk_term && lclk_reg;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || !loading)
    begin
      lclk_cnt_reg <= 4'h0;
      lclk_reg     <= 1'b0;
    end
    else if (lclk_term)
    begin
      lclk_cnt_reg <= 4'h0;
      lclk_reg     <= !lclk_reg;
    end
    else
      lclk_cnt_reg <= lclk_cnt_reg + 4'h1;
  end

  // Command shifter; memory samples on rise, so we launch on fall
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || state_reg != as_cfg_pkg::ST_CMD)
    begin
      bit_cnt_reg <= 6'h0;
      shift_reg   <= {as_cfg_pkg::READ_CMD, as_cfg_pkg::READ_ADDR};
    end
    else if (lclk_fall)
    begin
      bit_cnt_reg <= bit_cnt_reg + 6'h1;
      shift_reg   <= {shift_reg[30:0], 1'b0};
    end
  end

  // Data capture on falling edges, most significant bit first
  always_ff @(posedge i_sys_clk)
  begin
    raw_valid_reg <= 1'b0;
    if (i_srst || state_reg != as_cfg_pkg::ST_DATA)
    begin
      byte_reg      <= 8'h00;
      byte_bits_reg <= 3'h0;
      raw_valid_reg <= 1'b0;
    end
    else if (lclk_fall)
    begin
      byte_reg      <= {byte_reg[6:0], pin_sync_w[3]};
      byte_bits_reg <= byte_bits_reg + 3'h1;
      raw_valid_reg <= byte_bits_reg == 3'h7;
    end
  end

  // Output byte count; first byte carries the init-done enable
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || state_reg == as_cfg_pkg::ST_WAIT_ST || state_reg == as_cfg_pkg::ST_RECONFIG
        || state_reg == as_cfg_pkg::ST_RESTART)
    begin
      out_cnt_reg <= 24'h0;
      first_reg   <= 1'b1;
      ide_reg     <= 1'b0;
    end
    else if (dec_if.valid && state_reg == as_cfg_pkg::ST_DATA)
    begin
      out_cnt_reg <= out_cnt_reg + 24'h1;
      first_reg   <= 1'b0;
      if (first_reg)
        ide_reg <= dec_if.data[0];
    end
  end

  // Init clock: internal 10 MHz divider or user clock edges
  assign init_tick = state_reg == as_cfg_pkg::ST_INIT
                     && (ctrl_reg[as_cfg_pkg::CTRL_UCLK_BIT] ? pin_rise_w[4]
                         : init_div_reg == 4'(as_cfg_pkg::INIT_DIV - 1));
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || state_reg != as_cfg_pkg::ST_INIT)
    begin
      init_div_reg <= 4'h0;
      init_cnt_reg <= 8'h0;
    end
    else
    begin
      init_div_reg <= (init_div_reg == 4'(as_cfg_pkg::INIT_DIV - 1)) ? 4'h0 : init_div_reg + 4'h1;
      if (init_tick)
        init_cnt_reg <= init_cnt_reg + 8'h1;
    end
  end

  // Pin drive decoded from the registered state
  assign o_status_line_oe = state_reg == as_cfg_pkg::ST_POR || state_reg == as_cfg_pkg::ST_ERROR
                            || state_reg == as_cfg_pkg::ST_RESTART
                            || state_reg == as_cfg_pkg::ST_RECONFIG;
  assign o_done_line_oe   = !(state_reg == as_cfg_pkg::ST_WAIT_DN || state_reg == as_cfg_pkg::ST_INIT
                            || state_reg == as_cfg_pkg::ST_USER);
  assign o_init_done_oe   = ide_reg && state_reg != as_cfg_pkg::ST_USER;
  assign o_memory_chip_select_n = !(loading || (state_reg == as_cfg_pkg::ST_RESTART
                            && delay_reg < 32'(as_cfg_pkg::CS_PULSE_CYCLES)));
  assign o_serial_link_clock  = lclk_reg;
  assign o_command_serial_out = state_reg == as_cfg_pkg::ST_CMD && shift_reg[31];
  assign o_user_io_tristate   = state_reg != as_cfg_pkg::ST_USER;
  assign o_weak_pullup_en     = state_reg != as_cfg_pkg::ST_USER;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  sequence s_err_entry;
    state_reg == as_cfg_pkg::ST_DATA && i_frame_error && rcfg_n;
  endsequence
  sequence s_err_drive;
    o_status_line_oe && o_done_line_oe;
  endsequence

  AST_POR_LINES_LOW: assert property (state_reg == as_cfg_pkg::ST_POR |-> o_status_line_oe && o_done_line_oe)
    else $error("status or done released during power-on reset");
  AST_START_NEEDS_STATUS: assert property ($rose(state_reg == as_cfg_pkg::ST_CMD) |-> $past(st_ok))
    else $error("loading started without status high");
  AST_PULLUP_BEFORE_USER: assert property (state_reg != as_cfg_pkg::ST_USER |-> o_weak_pullup_en && o_user_io_tristate)
    else $error("pull-ups off before user mode");
  AST_LCLK_HIGH_TIME: assert property (disable iff (i_srst || !loading) $rose(o_serial_link_clock) |-> o_serial_link_clock[*3] ##1 !o_serial_link_clock)
    else $error("serial clock high time wrong");
  AST_LCLK_STOPPED: assert property (!loading |=> !o_serial_link_clock)
    else $error("serial clock running outside loading");
  AST_LAUNCH_ON_FALL: assert property ($changed(o_command_serial_out) && state_reg == as_cfg_pkg::ST_CMD && $past(state_reg) == as_cfg_pkg::ST_CMD |-> $fell(o_serial_link_clock))
    else $error("command bit moved off the falling edge");
  AST_SELECT_WHILE_LOADING: assert property (loading |-> !o_memory_chip_select_n)
    else $error("memory not selected while loading");
  AST_DONE_RELEASED: assert property (state_reg == as_cfg_pkg::ST_WAIT_DN |-> !o_done_line_oe)
    else $error("done held low after all data");
  AST_INIT_AFTER_DONE: assert property ($rose(state_reg == as_cfg_pkg::ST_INIT) |-> $past(dn_ok))
    else $error("initialisation without done high");
  AST_INIT_COUNT: assert property (init_tick && init_cnt_reg == 8'(as_cfg_pkg::INIT_CYCLES - 1) && rcfg_n |=> state_reg == as_cfg_pkg::ST_USER)
    else $error("user mode not entered after 136 init clocks");
  AST_INIT_DONE_LOW: assert property (ide_reg && state_reg == as_cfg_pkg::ST_INIT |-> o_init_done_oe)
    else $error("init-done not driven low during init");
  AST_USER_IO_LIVE: assert property (state_reg == as_cfg_pkg::ST_USER |-> !o_weak_pullup_en && !o_user_io_tristate)
    else $error("user mode still tri-stated");
  AST_FRAME_ERROR: assert property (s_err_entry |=> s_err_drive)
    else $error("frame error did not pull status and done low");
  AST_RESTART_PULSE: assert property ($rose(state_reg == as_cfg_pkg::ST_RESTART) |-> !o_memory_chip_select_n[*8] ##3 o_memory_chip_select_n)
    else $error("restart select pulse wrong");
  AST_RECONFIG_LOW: assert property (!rcfg_n && state_reg != as_cfg_pkg::ST_POR |=> o_status_line_oe && o_done_line_oe && o_user_io_tristate)
    else $error("reconfig request not honoured");
endmodule : active_serial_config_master

// *** flash_model.sv ***
// Behavioural serial configuration memory answering the read command
`timescale 1ns/1ps
module flash_model (
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_cmd,
  output logic      o_data
);
  logic [7:0]  mem [0:7];
  logic [31:0] cmd_word;
  int          bit_cnt;
  int          out_cnt;
  // Idle line sits at its weak pull-up level
  initial
  begin
    bit_cnt = 0;
    out_cnt = 0;
    o_data = 1'h1;
  end
  // Command and address bits are taken on the rising edge
  always @(posedge i_sck)
    if (!i_cs_n && bit_cnt < 32)
    begin
      cmd_word <= {cmd_word[30:0], i_cmd};
      bit_cnt <= bit_cnt + 1;
    end
  // Data launched on the falling edge once the header is in
  always @(negedge i_sck)
    if (!i_cs_n && bit_cnt == 32)
    begin
      o_data <= mem[out_cnt[5:3]][3'h7 - out_cnt[2:0]];
      out_cnt <= out_cnt + 1;
    end
  // Deselect restarts the command and lets the line float high
  always @(posedge i_cs_n)
  begin
    bit_cnt <= 0;
    out_cnt <= 0;
    o_data <= 1'h1;
  end
endmodule : flash_model

// *** active_serial_config_master_tb_top.sv ***
// Self-checking bench for the serial configuration loader
`timescale 1ns/1ps
module active_serial_config_master_tb_top;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, cfg_byte;
  logic [31:0] pwdata, prdata, rd;
  logic        reconf_n, ferr, uclk, sck, cmd, cs_n, dat, st_oe, dn_oe, id_oe;
  logic        cfg_valid, tris, pull, sck_d, chain_n;
  logic [1:0]  scheme;
  logic [7:0]  got_q[$];
  int          fail_count, comparisons, per, last_per, rises, cs_lo, n, r0;

  // Status and done wires only see their pull-ups when released
  active_serial_config_master #(.POR_CYCLES(200)) i_dut (
    .i_sys_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_scheme_select(scheme), .i_chain_enable_in_n(chain_n), .i_reconfig_request_n(reconf_n),
    .i_status_line(!st_oe), .o_status_line_oe(st_oe), .i_done_line(!dn_oe), .o_done_line_oe(dn_oe),
    .o_init_done_oe(id_oe), .i_user_startup_clock(uclk), .o_serial_link_clock(sck),
    .o_command_serial_out(cmd), .o_memory_chip_select_n(cs_n), .i_bitstream_data_in(dat),
    .i_frame_error(ferr), .o_cfg_valid(cfg_valid), .o_cfg_byte(cfg_byte),
    .o_user_io_tristate(tris), .o_weak_pullup_en(pull));
  flash_model i_mem (.i_sck(sck), .i_cs_n(cs_n), .i_cmd(cmd), .o_data(dat));

  // System clock and an unrelated user start-up clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    uclk = 1'h0;
    forever #40 uclk = ~uclk;
  end
  // Serial clock period, edge count, select pulses and output bytes
  always @(posedge clk)
  begin
    sck_d <= sck;
    per <= (sck && !sck_d) ? 1 : per + 1;
    if (sck && !sck_d)
    begin
      last_per <= per;
      rises <= rises + 1;
    end
    if (!cs_n && st_oe)
      cs_lo <= cs_lo + 1;
    if (cfg_valid === 1'h1)
      got_q.push_back(cfg_byte);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    rd = prdata;
    err = pslverr;
    check("pready", pready, 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_val(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 20000)
    begin
      @(posedge clk);
      c++;
    end
    check("wait", s, v);
  endtask : wait_val

  task automatic set_mem(input logic [31:0] w);
    for (int i = 0; i < 8; i++)
      i_mem.mem[i] = (i < 4) ? w[31-8*i -: 8] : 8'h00;
  endtask : set_mem

  // Request a reload, obeying the minimum low time of 40 us
  task automatic reload(input logic [31:0] ctrl, input logic [31:0] w);
    apb(1'h1, as_cfg_pkg::CTRL_OFF, ctrl);
    set_mem(w);
    reconf_n <= 1'h0;
    repeat (4000) @(posedge clk);
    check("reconf_status", st_oe, 1'h1);
    check("reconf_done", dn_oe, 1'h1);
    check("reconf_io", tris, 1'h1);
    got_q.delete();
    reconf_n <= 1'h1;
  endtask : reload

  // Done release, start-up length, user mode entry and received bytes
  task automatic finish_load(input logic [31:0] exp, input logic ide, input int lo, input int hi);
    wait_val(dn_oe, 1'h0, n);
    check("init_done_oe", id_oe, ide);
    wait_val(tris, 1'h0, n);
    check("init_len", n >= lo && n <= hi, 1'h1);
    check("init_done_rel", id_oe, 1'h0);
    check("pullup", pull, 1'h0);
    check("bytes", got_q.size(), 32'h4);
    for (int i = 0; i < 4; i++)
      check("byte", got_q[i], exp[31-8*i -: 8]);
    check("cmd", i_mem.cmd_word, 32'h03000000);
    r0 = rises;
    repeat (30) @(posedge clk);
    check("sck_stop", rises, r0);
    check("cs_idle", cs_n, 1'h1);
  endtask : finish_load

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Hang guard, well beyond the expected 30000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ferr} = '0;
    reconf_n = 1'h1;
    scheme = 2'h1;
    chain_n = 1'h0;
    srst = 1'h1;
    {fail_count, comparisons, per, last_per, rises, cs_lo} = '0;
    set_mem(32'h01a5f37e);
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    check("por_status", st_oe, 1'h1);
    check("por_done", dn_oe, 1'h1);
    check("por_io", tris & pull, 1'h1);
    apb(1'h0, as_cfg_pkg::CTRL_OFF, 32'h0);
    check("ctrl_rst", rd, 32'h0);
    apb(1'h0, as_cfg_pkg::LEN_OFF, 32'h0);
    check("len_rst", rd, 32'h10);
    apb(1'h0, 8'h0c, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'h1, as_cfg_pkg::LEN_OFF, 32'h4);
    check("cs_por", cs_n, 1'h1);
    wait_val(st_oe, 1'h0, n);
    repeat (20) @(posedge clk);
    check("scheme_hold", cs_n, 1'h1);
    scheme <= 2'h0;
    chain_n <= 1'h1;
    repeat (20) @(posedge clk);
    check("chain_hold", cs_n, 1'h1);
    chain_n <= 1'h0;
    wait_val(cs_n, 1'h0, n);
    finish_load(32'h01a5f37e, 1'h1, 1360, 1380);
    check("sck_period", last_per >= 5 && last_per <= 7, 1'h1);
    $display("Test power_on_load done");
    reload(32'h6, 32'hf2f0f509);
    finish_load(32'h0000f509, 1'h0, 1080, 1110);
    $display("Test compressed_user_clock done");
    reload(32'h1, 32'h01a5f37e);
    n = 0;
    while (got_q.size() == 0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    ferr <= 1'h1;
    r0 = cs_lo;
    @(posedge clk);
    ferr <= 1'h0;
    got_q.delete();
    repeat (4) @(posedge clk);
    check("err_status", st_oe, 1'h1);
    check("err_done", dn_oe, 1'h1);
    wait_val(st_oe, 1'h0, n);
    check("restart_wait", n >= 2985 && n <= 3030, 1'h1);
    check("cs_pulse", cs_lo - r0 >= 1 && cs_lo - r0 <= 12, 1'h1);
    finish_load(32'h01a5f37e, 1'h1, 1360, 1380);
    apb(1'h0, as_cfg_pkg::CTRL_OFF, 32'h0);
    check("ctrl_rd", rd, 32'h1);
    apb(1'h0, as_cfg_pkg::STAT_OFF, 32'h0);
    check("stat_err", rd[6:0], 7'h76);
    apb(1'h1, as_cfg_pkg::STAT_OFF, 32'h10);
    apb(1'h0, as_cfg_pkg::STAT_OFF, 32'h0);
    check("stat_clr", rd[4], 1'h0);
    $display("Test frame_error_restart done");
    // Without auto restart the error must hold until the host reloads
    reload(32'h0, 32'h01a5f37e);
    wait_val(cfg_valid, 1'h1, n);
    ferr <= 1'h1;
    @(posedge clk);
    ferr <= 1'h0;
    repeat (3500) @(posedge clk);
    check("err_hold", st_oe & dn_oe & cs_n, 1'h1);
    reload(32'h0, 32'h01a5f37e);
    finish_load(32'h01a5f37e, 1'h1, 1360, 1380);
    $display("Test frame_error_host_reload done");
    wrap_up();
  end
endmodule : active_serial_config_master_tb_top
